// *** logic/cls_pkg.sv ***
`default_nettype none
package cls_pkg;
   localparam int CLK_NS    = 20;
   localparam int CNT_W     = 20;
   localparam int WORD_W    = 32;
   localparam int FIFO_DEPTH = 8;

   // Times and cycle counts
   localparam int POR_US        = 100;
   localparam int STATUS_LOW_US = 268;
   localparam int INIT_OSC_US   = 175;
   localparam int CD2CU_NS      = 40;
   localparam int INIT_USER_CNT = 8576;

   localparam logic [CNT_W-1:0] POR_CYC =
      CNT_W'((POR_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] STATUS_LOW_CYC =
      CNT_W'((STATUS_LOW_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] INIT_OSC_CYC =
      CNT_W'((INIT_OSC_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] SWITCH_CYC =
      CNT_W'((CD2CU_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] INIT_USER_EDGES = CNT_W'(INIT_USER_CNT);
   localparam logic [CNT_W-1:0] TAIL_FALLS = 20'h00002;

   // Fields
   localparam int OPT_INIT_POS = 0;
   localparam int OPT_USER_POS = 1;
   localparam logic [1:0] WID_X8  = 2'h0;
   localparam logic [1:0] WID_X16 = 2'h1;
   localparam logic [1:0] BAND_TOP  = 2'h3;
   localparam logic [1:0] BAND_SAFE = 2'h2;
   localparam logic [5:0] WORD_BITS = 6'h20;
   localparam logic [5:0] CMD_BITS  = 6'h20;
   localparam logic [5:0] CMD_DONE  = 6'h21;
   localparam logic [31:0] AS_CMD_WORD = 32'h03000000;
   localparam logic [3:0] AS_HALF_B0 = 4'h8;
   localparam logic [3:0] AS_HALF_B1 = 4'h4;
   localparam logic [3:0] AS_HALF_B2 = 4'h2;

   typedef enum logic [2:0] {
      ST_POR    = 3'h0,
      ST_CLEAR  = 3'h1,
      ST_LOAD   = 3'h2,
      ST_TAIL   = 3'h3,
      ST_SWITCH = 3'h4,
      ST_INIT   = 3'h5,
      ST_USER   = 3'h6,
      ST_ERROR  = 3'h7
   } cls_state_t;

   function automatic logic [5:0] cls_beat_bits(input logic as_mode,
      input logic x4, input logic [1:0] wid);
      if (as_mode) begin
         cls_beat_bits = x4 ? 6'h04 : 6'h01;
      end else if (wid == WID_X8) begin
         cls_beat_bits = 6'h08;
      end else if (wid == WID_X16) begin
         cls_beat_bits = 6'h10;
      end else begin
         cls_beat_bits = 6'h20;
      end
   endfunction

   // First beat ends in low bits
   function automatic logic [31:0] cls_shift_in(input logic [31:0] acc,
      input logic [31:0] beat, input logic [5:0] bits);
      case (bits)
         6'h01:   cls_shift_in = {beat[0], acc[31:1]};
         6'h04:   cls_shift_in = {beat[3:0], acc[31:4]};
         6'h08:   cls_shift_in = {beat[7:0], acc[31:8]};
         6'h10:   cls_shift_in = {beat[15:0], acc[31:16]};
         default: cls_shift_in = beat;
      endcase
   endfunction

   function automatic logic [3:0] cls_as_half(input logic [1:0] band);
      case (band)
         2'h0:    cls_as_half = AS_HALF_B0;
         2'h1:    cls_as_half = AS_HALF_B1;
         default: cls_as_half = AS_HALF_B2;
      endcase
   endfunction
endpackage
`default_nettype wire

// *** logic/cls_word_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface cls_word_if #(parameter int W = 32);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** logic/cls_pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module cls_pin_sync #(
   parameter int W = 1
) (
   // Clocking
   input  wire logic         clk,
   input  wire logic         rst_b,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= '0;
         q    <= '0;
      end else begin
         s1_r <= d;
         q    <= s1_r;
      end
   end
endmodule
`default_nettype wire

// *** logic/cls_word_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module cls_word_fifo #(
   parameter int W     = 32,
   parameter int DEPTH = 8
) (
   // Clocking
   input  wire logic  clk,
   input  wire logic  rst_b,
   // Sides
   cls_word_if.sink   fill,
   cls_word_if.source drain
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_r;
   logic [AW:0]  rd_r;
   logic         full;
   logic         empty;

   assign empty = (wr_r == rd_r);
   assign full  = (wr_r[AW] != rd_r[AW]) &&
                  (wr_r[AW-1:0] == rd_r[AW-1:0]);
   assign fill.ready  = !full;
   assign drain.valid = !empty;
   assign drain.data  = mem[rd_r[AW-1:0]];

   always_ff @(posedge clk) begin
      if (fill.valid && !full) begin
         mem[wr_r[AW-1:0]] <= fill.data;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (fill.valid && !full) begin
            wr_r <= wr_r + 1'b1;
         end
         if (drain.ready && !empty) begin
            rd_r <= rd_r + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** logic/cls_config_load_sequencer.sv ***
// Function
// - User mode: lines high; request low reconfigures
// - Status held low for power-on delay
// - Completion low from power-up through loading
// - Completion released after full error-free image
// - Enabled init-complete output low until initialized
// - Status low pulse 268 to 1506 us
// - Status and completion low within 600 ns
// - Oscillator init reaches user mode 175-437 us
// - User clock: switch after 4 periods, 8576 edges
// - Serial clock in three rates (band 3 runs as band 2), slowest 3.125 MHz
// - No fastest serial band in chained setups; code maps band 3 to band 2, which runs at the same rate
// - Four-bit serial mode takes four bits per clock
// - Serial launch and capture on falling edge
// - Init clock from oscillator or user pin
`timescale 1ns/10ps
`default_nettype none
module cls_config_load_sequencer #(
   parameter logic [19:0] POR_CYC         = cls_pkg::POR_CYC,
   parameter logic [19:0] STATUS_LOW_CYC  = cls_pkg::STATUS_LOW_CYC,
   parameter logic [19:0] INIT_OSC_CYC    = cls_pkg::INIT_OSC_CYC,
   parameter logic [19:0] INIT_USER_EDGES = cls_pkg::INIT_USER_EDGES
) (
   // Clocking
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // Straps
   input  wire logic        active_serial_load,
   input  wire logic [1:0]  par_width,
   input  wire logic [2:0]  ratio_m1,
   input  wire logic        as_x4,
   input  wire logic [1:0]  as_band,
   input  wire logic        as_chain,
   // Image length
   input  wire logic [23:0] image_words,
   // Handshake pins
   input  wire logic        config_req_b,
   input  wire logic        status_b_in,
   output logic             status_b_out,
   output logic             status_b_oe,
   input  wire logic        done_in,
   output logic             done_out,
   output logic             done_oe,
   output logic             init_done_out,
   output logic             init_done_oe,
   // Parallel pins
   input  wire logic        config_clock,
   input  wire logic [31:0] par_data,
   // Serial pins
   output logic             config_clock_out,
   output logic             config_clock_oe,
   output logic             mem_sel_b,
   output logic             memory_serial_out,
   input  wire logic [3:0]  memory_data_lines,
   // Init clock
   input  wire logic        user_init_clock,
   // Words out
   output logic [31:0]      cfg_word,
   output logic             cfg_word_valid,
   input  wire logic        cfg_word_ready,
   output logic             user_mode
);
   cls_pkg::cls_state_t state_r;

   logic [50:0] pin_q;
   logic        as_s;
   logic [1:0]  wid_s;
   logic [2:0]  ratio_s;
   logic        x4_s;
   logic [1:0]  band_s;
   logic        chain_s;
   logic        req_b_s;
   logic        stat_s;
   logic        done_s;
   logic        cclk_s;
   logic        uclk_s;
   logic [3:0]  mdat_s;
   logic [31:0] pdat_s;

   logic        cclk_d_r;
   logic        uclk_d_r;
   logic        req_d_r;
   logic [19:0] cnt_r;
   logic [2:0]  ratio_cnt_r;
   logic [31:0] acc_r;
   logic [5:0]  bits_r;
   logic [23:0] words_r;
   logic        fill_valid_r;
   logic [31:0] fill_data_r;
   logic        opt_init_r;
   logic        opt_user_r;
   logic [3:0]  as_div_r;
   logic        as_clk_r;
   logic [5:0]  cmd_cnt_r;
   logic [31:0] cmd_sh_r;
   logic        mso_r;
   logic        msel_b_r;
   logic        as_oe_r;
   logic        out_valid_r;
   logic [31:0] out_data_r;
   logic        status_oe_r;
   logic        done_oe_r;
   logic        init_oe_r;
   logic        init_out_r;
   logic        user_r;

   logic        cclk_rise;
   logic        cclk_fall;
   logic        uclk_rise;
   logic        req_fall;
   logic        loading;
   logic [1:0]  band_eff;
   logic [3:0]  as_half;
   logic        as_run;
   logic        as_tog;
   logic        as_fall;
   logic        beat_en;
   logic [31:0] beat;
   logic [5:0]  beat_bits;
   logic [5:0]  bits_sum;
   logic        word_done;
   logic [31:0] acc_nxt;
   logic        overflow;
   logic        load_done;
   logic [19:0] init_limit;
   logic        init_tick;

   cls_word_if #(.W(cls_pkg::WORD_W)) fill_if ();
   cls_word_if #(.W(cls_pkg::WORD_W)) drain_if ();

   cls_pin_sync #(.W(51)) u_sync (
      .clk   (sys_clk),
      .rst_b (rst_b),
      .d     ({active_serial_load, par_width, ratio_m1, as_x4, as_band,
               as_chain, config_req_b, status_b_in, done_in, config_clock,
               user_init_clock, memory_data_lines, par_data}),
      .q     (pin_q)
   );

   assign {as_s, wid_s, ratio_s, x4_s, band_s, chain_s, req_b_s, stat_s,
           done_s, cclk_s, uclk_s, mdat_s, pdat_s} = pin_q;

   cls_word_fifo #(.W(cls_pkg::WORD_W), .DEPTH(cls_pkg::FIFO_DEPTH)) u_fifo (
      .clk   (sys_clk),
      .rst_b (rst_b),
      .fill  (fill_if),
      .drain (drain_if)
   );

   assign fill_if.valid  = fill_valid_r;
   assign fill_if.data   = fill_data_r;
   assign drain_if.ready = !out_valid_r || cfg_word_ready;

   // Pin edges
   assign cclk_rise = cclk_s && !cclk_d_r;
   assign cclk_fall = !cclk_s && cclk_d_r;
   assign uclk_rise = uclk_s && !uclk_d_r;
   assign req_fall  = req_d_r && !req_b_s;
   assign loading   = (state_r == cls_pkg::ST_LOAD);

   // Serial beats
   assign band_eff = (chain_s && band_s == cls_pkg::BAND_TOP) ?
                     cls_pkg::BAND_SAFE : band_s;
   assign as_half  = cls_pkg::cls_as_half(band_eff);
   assign as_run   = loading && as_s && fill_if.ready && !fill_valid_r;
   assign as_tog   = as_run && (as_div_r == as_half - 4'h1);
   assign as_fall  = as_tog && as_clk_r;

   assign beat      = as_s ? {28'h0000000, mdat_s} : pdat_s;
   assign beat_bits = cls_pkg::cls_beat_bits(as_s, x4_s, wid_s);
   assign beat_en   = as_s ? (as_fall && cmd_cnt_r == cls_pkg::CMD_DONE) :
                      (loading && stat_s && cclk_rise &&
                       ratio_cnt_r == 3'h0);
   assign bits_sum  = bits_r + beat_bits;
   assign word_done = beat_en && (bits_sum == cls_pkg::WORD_BITS);
   assign acc_nxt   = cls_pkg::cls_shift_in(acc_r, beat, beat_bits);
   assign overflow  = fill_valid_r && !fill_if.ready;
   assign load_done = (words_r == image_words) && !fill_valid_r;

   assign init_limit = opt_user_r ? INIT_USER_EDGES : INIT_OSC_CYC;
   assign init_tick  = opt_user_r ? uclk_rise : 1'b1;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cclk_d_r <= 1'b0;
         uclk_d_r <= 1'b0;
         req_d_r  <= 1'b1;
      end else begin
         cclk_d_r <= cclk_s;
         uclk_d_r <= uclk_s;
         req_d_r  <= req_b_s;
      end
   end

   // Sequencing
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= cls_pkg::ST_POR;
         cnt_r   <= 20'h00000;
      end else if (state_r != cls_pkg::ST_POR && req_fall) begin
         state_r <= cls_pkg::ST_CLEAR;
         cnt_r   <= 20'h00000;
      end else begin
         case (state_r)
            cls_pkg::ST_POR: begin
               if (cnt_r == POR_CYC - 20'h00001) begin
                  state_r <= req_b_s ? cls_pkg::ST_LOAD : cls_pkg::ST_CLEAR;
                  cnt_r   <= 20'h00000;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            cls_pkg::ST_CLEAR: begin
               if (cnt_r < STATUS_LOW_CYC) begin
                  cnt_r <= cnt_r + 1'b1;
               end else if (req_b_s) begin
                  state_r <= cls_pkg::ST_LOAD;
                  cnt_r   <= 20'h00000;
               end
            end
            cls_pkg::ST_LOAD: begin
               if (overflow) begin
                  state_r <= cls_pkg::ST_ERROR;
               end else if (load_done) begin
                  state_r <= cls_pkg::ST_TAIL;
               end
            end
            cls_pkg::ST_TAIL: begin
               if (done_s && (as_s || cnt_r == cls_pkg::TAIL_FALLS)) begin
                  state_r <= opt_user_r ? cls_pkg::ST_SWITCH :
                             cls_pkg::ST_INIT;
                  cnt_r   <= 20'h00000;
               end else if (done_s && cclk_fall) begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            cls_pkg::ST_SWITCH: begin
               if (cnt_r == cls_pkg::SWITCH_CYC - 20'h00001) begin
                  state_r <= cls_pkg::ST_INIT;
                  cnt_r   <= 20'h00000;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            cls_pkg::ST_INIT: begin
               if (cnt_r == init_limit) begin
                  state_r <= cls_pkg::ST_USER;
               end else if (init_tick) begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            cls_pkg::ST_USER: state_r <= cls_pkg::ST_USER;
            cls_pkg::ST_ERROR: state_r <= cls_pkg::ST_ERROR;
            default: state_r <= cls_pkg::ST_POR;
         endcase
      end
   end

   // Words
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ratio_cnt_r  <= 3'h0;
         acc_r        <= 32'h00000000;
         bits_r       <= 6'h00;
         words_r      <= 24'h000000;
         fill_valid_r <= 1'b0;
         fill_data_r  <= 32'h00000000;
         opt_init_r   <= 1'b0;
         opt_user_r   <= 1'b0;
      end else begin
         fill_valid_r <= word_done && !overflow;
         if (state_r == cls_pkg::ST_CLEAR || state_r == cls_pkg::ST_POR) begin
            ratio_cnt_r <= 3'h0;
            bits_r      <= 6'h00;
            words_r     <= 24'h000000;
            opt_init_r  <= 1'b0;
            opt_user_r  <= 1'b0;
         end else begin
            if (loading && !as_s && stat_s && cclk_rise) begin
               ratio_cnt_r <= (ratio_cnt_r == ratio_s) ? 3'h0 :
                              ratio_cnt_r + 1'b1;
            end
            if (beat_en) begin
               acc_r  <= acc_nxt;
               bits_r <= word_done ? 6'h00 : bits_sum;
            end
            if (word_done) begin
               words_r     <= words_r + 1'b1;
               fill_data_r <= acc_nxt;
               if (words_r == 24'h000000) begin
                  opt_init_r <= acc_nxt[cls_pkg::OPT_INIT_POS];
                  opt_user_r <= acc_nxt[cls_pkg::OPT_USER_POS];
               end
            end
         end
      end
   end

   // Serial clock
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         as_div_r  <= 4'h0;
         as_clk_r  <= 1'b0;
         cmd_cnt_r <= 6'h00;
         cmd_sh_r  <= cls_pkg::AS_CMD_WORD;
         mso_r     <= 1'b0;
         msel_b_r  <= 1'b1;
         as_oe_r   <= 1'b0;
      end else begin
         as_oe_r  <= as_s;
         msel_b_r <= !(loading && as_s);
         if (!(loading && as_s)) begin
            as_div_r  <= 4'h0;
            as_clk_r  <= 1'b0;
            cmd_cnt_r <= 6'h00;
            cmd_sh_r  <= cls_pkg::AS_CMD_WORD;
         end else if (as_run) begin
            as_div_r <= as_tog ? 4'h0 : as_div_r + 1'b1;
            if (as_tog) begin
               as_clk_r <= !as_clk_r;
            end
            if (as_fall) begin
               if (cmd_cnt_r < cls_pkg::CMD_BITS) begin
                  mso_r    <= cmd_sh_r[31];
                  cmd_sh_r <= {cmd_sh_r[30:0], 1'b0};
               end
               if (cmd_cnt_r != cls_pkg::CMD_DONE) begin
                  cmd_cnt_r <= cmd_cnt_r + 1'b1;
               end
            end
         end
      end
   end

   // Word out
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_valid_r <= 1'b0;
         out_data_r  <= 32'h00000000;
      end else if (drain_if.ready) begin
         out_valid_r <= drain_if.valid;
         out_data_r  <= drain_if.data;
      end
   end

   // Pin drive
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_oe_r <= 1'b1;
         done_oe_r   <= 1'b1;
         init_oe_r   <= 1'b0;
         init_out_r  <= 1'b0;
         user_r      <= 1'b0;
      end else begin
         status_oe_r <= (state_r == cls_pkg::ST_POR) ||
                        (state_r == cls_pkg::ST_CLEAR) ||
                        (state_r == cls_pkg::ST_ERROR);
         done_oe_r   <= (state_r == cls_pkg::ST_POR) ||
                        (state_r == cls_pkg::ST_CLEAR) ||
                        (state_r == cls_pkg::ST_LOAD) ||
                        (state_r == cls_pkg::ST_ERROR);
         init_oe_r   <= opt_init_r;
         init_out_r  <= (state_r == cls_pkg::ST_USER);
         user_r      <= (state_r == cls_pkg::ST_USER);
      end
   end

   assign status_b_out      = 1'b0;
   assign done_out          = 1'b0;
   assign status_b_oe       = status_oe_r;
   assign done_oe           = done_oe_r;
   assign init_done_oe      = init_oe_r;
   assign init_done_out     = init_out_r;
   assign config_clock_out  = as_clk_r;
   assign config_clock_oe   = as_oe_r;
   assign mem_sel_b         = msel_b_r;
   assign memory_serial_out = mso_r;
   assign cfg_word          = out_data_r;
   assign cfg_word_valid    = out_valid_r;
   assign user_mode         = user_r;
endmodule
`default_nettype wire

// *** test/cls_sequencer_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module cls_sequencer_asserts #(
   parameter logic [19:0] POR_CYC        = 20'h00014,
   parameter logic [19:0] STATUS_LOW_CYC = 20'h0001e,
   parameter logic [19:0] INIT_OSC_CYC   = 20'h00028
) (
   // Clocking
   input wire logic        sys_clk,
   input wire logic        rst_b,
   // Watched
   input wire logic        config_req_b,
   input wire logic        status_b_oe,
   input wire logic        done_oe,
   input wire logic        init_done_out,
   input wire logic        init_done_oe,
   input wire logic [1:0]  as_band,
   input wire logic        config_clock_out,
   input wire logic        mem_sel_b,
   input wire logic        memory_serial_out,
   input wire logic [31:0] cfg_word,
   input wire logic        cfg_word_valid,
   input wire logic        cfg_word_ready,
   input wire logic        user_mode
);
   logic [19:0] up_r;
   logic [19:0] req_r;
   logic [19:0] cd_r;
   logic        por_r;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Elapsed cycles
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         up_r  <= 20'h00000;
         req_r <= 20'h00000;
         cd_r  <= 20'h00000;
         por_r <= 1'b1;
      end else begin
         up_r  <= (up_r == 20'hfffff) ? up_r : up_r + 20'h00001;
         req_r <= $fell(config_req_b) ? 20'h00000 : req_r + 20'h00001;
         cd_r  <= done_oe ? 20'h00000 : cd_r + 20'h00001;
         por_r <= por_r && !$fell(config_req_b);
      end
   end
   por_hold_a: assert property (up_r < POR_CYC |-> status_b_oe && done_oe)
      else $error("early release");
   req_answer_a: assert property ($fell(config_req_b) |-> ##[1:4] (status_b_oe && done_oe))
      else $error("late answer");
   user_lines_a: assert property (user_mode |-> !status_b_oe && !done_oe)
      else $error("low in user mode");
   done_user_a: assert property (done_oe |-> !user_mode)
      else $error("early user mode");
   status_len_a: assert property ($fell(status_b_oe) && !por_r |-> req_r > STATUS_LOW_CYC)
      else $error("short status");
   init_time_a: assert property ($rose(user_mode) |-> cd_r >= INIT_OSC_CYC)
      else $error("short init");
   init_out_a: assert property (init_done_oe && !user_mode |-> !init_done_out)
      else $error("early init out");
   launch_edge_a: assert property (!mem_sel_b && !$past(mem_sel_b) && $changed(memory_serial_out) |-> $fell(config_clock_out))
      else $error("late launch");
   band_slow_a: assert property ($rose(config_clock_out) && as_band == 2'h0 |-> config_clock_out [*8])
      else $error("band 0 fast");
   band_fast_a: assert property ($rose(config_clock_out) |-> config_clock_out [*2])
      else $error("clock fast");
   word_hold_a: assert property (cfg_word_valid && !cfg_word_ready |=> cfg_word_valid && $stable(cfg_word))
      else $error("word lost");
   cover property ($rose(user_mode));
   cover property ($fell(mem_sel_b));
   cover property ($rose(init_done_oe));
endmodule
bind cls_config_load_sequencer cls_sequencer_asserts #(
   .POR_CYC(POR_CYC), .STATUS_LOW_CYC(STATUS_LOW_CYC),
   .INIT_OSC_CYC(INIT_OSC_CYC)
) cls_sequencer_asserts_inst (.sys_clk, .rst_b, .config_req_b, .status_b_oe,
   .done_oe, .init_done_out, .init_done_oe, .as_band, .config_clock_out,
   .mem_sel_b, .memory_serial_out, .cfg_word, .cfg_word_valid,
   .cfg_word_ready, .user_mode);
`default_nettype wire

// *** test/cls_far_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cls_far_model (
   // Seen
   input  wire logic        status_w,
   input  wire logic        done_w,
   input  wire logic        as_x4,
   input  wire logic        config_clock_out,
   input  wire logic        mem_sel_b,
   input  wire logic        memory_serial_out,
   // Drive
   output logic             config_clock,
   output logic [31:0]      par_data,
   output logic [3:0]       memory_data_lines
);
   logic [31:0] img [16];
   logic [31:0] cmd_r;
   int          falls = 0;
   int          k = 0;
   initial begin
      config_clock = 1'b0;
      par_data = 32'h0;
      memory_data_lines = 4'h5;
   end
   // Status wait
   task automatic start;
      wait (status_w === 1'b1);
      #2000;
   endtask
   // Beats, n periods each
   task automatic send(input logic [31:0] w, input int bits, input int n);
      for (int b = 0; b < 32; b += bits) begin
         for (int r = 0; r < n; r++) begin
            if (r == 0) par_data = w >> b;
            #80 config_clock = 1'b1;
            #80 config_clock = 1'b0;
         end
      end
   endtask
   task automatic tail;
      par_data = ~par_data;
      wait (done_w === 1'b1);
      repeat (2) begin
         #80 config_clock = 1'b1;
         #80 config_clock = 1'b0;
      end
   endtask
   // Memory
   always @(negedge config_clock_out) begin
      if (!mem_sel_b) begin
         falls = falls + 1;
         if (falls >= 33) begin
            memory_data_lines = as_x4 ? img[k >> 3][4 * (k & 7) +: 4] :
               {~memory_data_lines[3:1], img[k >> 5][k & 31]};
            k = k + 1;
         end
      end
   end
   always @(posedge config_clock_out) begin
      if (!mem_sel_b && falls >= 1 && falls <= 32) cmd_r = {cmd_r[30:0], memory_serial_out};
   end
   always @(posedge mem_sel_b) begin
      falls = 0;
      k = 0;
      memory_data_lines = ~memory_data_lines;
   end
endmodule
`default_nettype wire

// *** test/cls_config_load_sequencer_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module cls_config_load_sequencer_bench;
   localparam logic [19:0] POR = 20'h00014;
   localparam logic [19:0] STL = 20'h0001e;
   localparam logic [19:0] IOC = 20'h00028;
   localparam logic [19:0] IUE = 20'h0000a;
   logic sys_clk = 1'b0, user_init_clock = 1'b0, rst_b, config_req_b;
   logic active_serial_load, as_x4, as_chain, cfg_word_ready = 1'b0;
   logic [1:0] par_width, as_band;
   logic [2:0] ratio_m1;
   logic [23:0] image_words;
   logic status_b_out, status_b_oe, done_out, done_oe, init_done_out;
   logic init_done_oe, config_clock, config_clock_out, config_clock_oe;
   logic mem_sel_b, memory_serial_out, cfg_word_valid, user_mode;
   logic stall = 1'b0, ign = 1'b0;
   logic [31:0] par_data, cfg_word;
   logic [3:0] memory_data_lines;
   logic [31:0] exp_q[$];
   int n_errors = 0, checked = 0, cd = 0, cyc;
   wire status_w = status_b_oe ? status_b_out : 1'b1;
   wire done_w = done_oe ? done_out : 1'b1;
   always #10 sys_clk = ~sys_clk;
   always #60 user_init_clock = ~user_init_clock;
   cls_config_load_sequencer #(.POR_CYC(POR), .STATUS_LOW_CYC(STL),
      .INIT_OSC_CYC(IOC), .INIT_USER_EDGES(IUE)) cls_config_load_sequencer_inst (
      .sys_clk, .rst_b, .active_serial_load, .par_width, .ratio_m1, .as_x4,
      .as_band, .as_chain, .image_words, .config_req_b, .status_b_in(status_w),
      .status_b_out, .status_b_oe, .done_in(done_w), .done_out, .done_oe,
      .init_done_out, .init_done_oe, .config_clock, .par_data, .config_clock_out,
      .config_clock_oe, .mem_sel_b, .memory_serial_out, .memory_data_lines,
      .user_init_clock, .cfg_word, .cfg_word_valid, .cfg_word_ready, .user_mode);
   cls_far_model cls_far_model_inst (.status_w, .done_w, .as_x4,
      .config_clock_out, .mem_sel_b, .memory_serial_out, .config_clock,
      .par_data, .memory_data_lines);
   task automatic chk(input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %0t: %h != %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic int beat_bits();
      return par_width[1] ? 32 : 8 << par_width[0];
   endfunction
   task automatic strap(input logic as);
      active_serial_load = as;
      par_width = 2'($urandom_range(0, 2));
      ratio_m1 = 3'($urandom_range(0, 3));
      as_x4 = 1'($urandom);
      as_band = 2'($urandom);
      as_chain = 1'($urandom);
   endtask
   task automatic req_pulse(input logic as);
      @(posedge sys_clk) #2 config_req_b = 1'b0;
      repeat (120) @(posedge sys_clk);
      strap(as);
      #2 config_req_b = 1'b1;
      for (cyc = 0; cyc < 3000 && status_w !== 1'b1; cyc++) @(posedge sys_clk);
   endtask
   task automatic run(input logic as, input logic [1:0] opt, input int nw, input logic rq);
      logic [31:0] w;
      int          lo;
      for (int i = 0; i < nw; i++) begin
         w = $urandom();
         if (i == 0) w[1:0] = opt;
         exp_q.push_back(w);
         cls_far_model_inst.img[i] = w;
      end
      image_words = 24'(nw);
      if (rq) req_pulse(as);
      if (!as) begin
         cls_far_model_inst.start();
         for (int i = 0; i < nw; i++) cls_far_model_inst.send(cls_far_model_inst.img[i], beat_bits(), ratio_m1 + 1);
         cls_far_model_inst.tail();
      end
      for (cyc = 0; cyc < 20000 && user_mode !== 1'b1; cyc++) @(posedge sys_clk);
      lo = opt[1] ? 2 + (IUE - 1) * 6 : IOC + 1;
      chk(32'(cd >= lo && cd < lo + 80), 32'h1);
      chk(32'({status_w, done_w, init_done_oe}), {29'h0, 2'h3, opt[0]});
      if (as) chk(cls_far_model_inst.cmd_r, cls_pkg::AS_CMD_WORD);
      chk(32'(config_clock_oe), 32'(as));
      repeat (40) @(posedge sys_clk);
      chk(32'(exp_q.size()), 32'h0);
   endtask
   always @(posedge sys_clk) cd <= done_w ? cd + 1 : 0;
   always @(posedge sys_clk) cfg_word_ready <= #2 !stall && 1'($urandom);
   always @(posedge sys_clk) begin
      if (cfg_word_valid === 1'b1 && cfg_word_ready === 1'b1 && !ign) chk(cfg_word, exp_q.size() ? exp_q.pop_front() : ~cfg_word);
   end
   initial begin
      #1_000_000;
      n_errors++;
      test_done();
   end
   initial begin
      rst_b = 1'b0;
      config_req_b = 1'b1;
      image_words = 24'h000003;
      cyc = $urandom(29);
      strap(1'b0);
      repeat (6) @(posedge sys_clk);
      #2 rst_b = 1'b1;
      for (cyc = 0; cyc < 500 && status_w !== 1'b1; cyc++) @(posedge sys_clk);
      chk(32'(cyc >= POR), 32'h1);
      run(1'b0, {1'b0, 1'($urandom)}, 3, 1'b0);
      // Overflow
      stall = 1'b1;
      req_pulse(1'b0);
      image_words = 24'h000010;
      cls_far_model_inst.start();
      for (int i = 0; i < 16; i++) cls_far_model_inst.send($urandom(), beat_bits(), ratio_m1 + 1);
      chk(32'({status_b_oe, done_oe}), 32'h3);
      ign = 1'b1;
      stall = 1'b0;
      repeat (40) @(posedge sys_clk);
      ign = 1'b0;
      run(1'b1, 2'h3, 3, 1'b1);
      test_done();
   end
endmodule
`default_nettype wire
